// ### design/brg_hdr_consts.svh
`ifndef BRG_HDR_CONSTS_SVH
`define BRG_HDR_CONSTS_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define BRG_IDX_W                 8
`define BRG_IDX_PRI_LATENCY       8'h0D
`define BRG_IDX_HEADER_TYPE       8'h0E
`define BRG_IDX_SELF_TEST         8'h0F
`define BRG_IDX_BASE_ADDR_ZERO    8'h10
`define BRG_IDX_BASE_ADDR_ONE     8'h14
`define BRG_IDX_UPSTREAM_BUS      8'h18
`define BRG_IDX_DOWNSTREAM_BUS    8'h19
`define BRG_IDX_HIGHEST_BUS       8'h1A
`define BRG_IDX_DOWN_LATENCY      8'h1B
`define BRG_IDX_IO_WINDOW_LOW     8'h1C
`define BRG_IDX_IO_WINDOW_HIGH    8'h1D
`define BRG_IDX_CAP_UNLOCK        8'h40

// ----------------------------------------------------------------------
// address and field positions
// ----------------------------------------------------------------------
`define BRG_IDX_MSB               9
`define BRG_IDX_LSB               2
`define BRG_IO_ADDR_MSB           7
`define BRG_IO_ADDR_LSB           4
`define BRG_IO_CAP_BIT            0
`define BRG_CAP_UNLOCK_BIT        0
`define BRG_STRB_LOW_LANE         0

// ----------------------------------------------------------------------
// reset and fixed values
// ----------------------------------------------------------------------
`define BRG_VAL_PRI_LATENCY       8'h00
`define BRG_VAL_HEADER_TYPE       8'h01
`define BRG_VAL_SELF_TEST         8'h00
`define BRG_VAL_BASE_ADDR         32'h00000000
`define BRG_VAL_DOWN_LATENCY      8'h00
`define BRG_RST_BUS_NUMBER        8'h00
`define BRG_RST_IO_LOW_ADDR       4'hF
`define BRG_RST_IO_HIGH_ADDR      4'h0
`define BRG_RST_IO_CAP            1'b1
`define BRG_RST_CAP_UNLOCK        1'b0
`define BRG_IO_RSVD_ZERO          3'h0

`endif

// ### design/brg_pkg.sv
package brg_pkg;

  // answer codes on the register bus
  typedef enum logic [1:0] {
    brg_resp_okay   = 2'h0,
    brg_resp_decerr = 2'h3
  } brg_resp_t;

  // addressing capability of the i/o window
  typedef enum logic {
    brg_sixteen_bit_io    = 1'b0,
    brg_thirtytwo_bit_io  = 1'b1
  } brg_io_mode_t;

  // write channel progress
  typedef enum logic [1:0] {
    brg_wr_collect = 2'b01,
    brg_wr_answer  = 2'b10
  } brg_wr_state_t;

endpackage

// ### design/brg_win_if.sv
`timescale 1ns/1ps

interface brg_win_if;
  logic                  [3:0] io_window_low;
  logic                  [3:0] io_window_high;
  brg_pkg::brg_io_mode_t       io_addressing_capability;
  logic                  [7:0] upstream_bus_number;
  logic                  [7:0] downstream_bus_number;
  logic                  [7:0] highest_behind_bus_number;
  logic                        cap_unlock;

  modport owner (
    output io_window_low,
    output io_window_high,
    output io_addressing_capability,
    output upstream_bus_number,
    output downstream_bus_number,
    output highest_behind_bus_number,
    output cap_unlock
  );

  modport view (
    input io_window_low,
    input io_window_high,
    input io_addressing_capability,
    input upstream_bus_number,
    input downstream_bus_number,
    input highest_behind_bus_number,
    input cap_unlock
  );
endinterface

// ### design/brg_io_decode.sv
`timescale 1ns/1ps
`include "brg_hdr_consts.svh"

module brg_io_decode (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  brg_win_if.view          win,
  input  wire logic        io_req_valid,
  input  wire logic [31:0] io_req_addr,
  output      logic        io_fwd_valid_r,
  output      logic        io_fwd_hit_r
);

  logic upper_ok;
  logic in_range;

  // ----------------------------------------------------------------------
  // window compare
  // ----------------------------------------------------------------------
  // upper address halves live in registers outside this slice, so in
  // 32-bit mode only bits 15:12 are judged here
  assign upper_ok = (win.io_addressing_capability == brg_pkg::brg_thirtytwo_bit_io) ||
                    (io_req_addr[31:16] == 16'h0000);
  // base above limit gives no match at all, i.e. an empty window
  assign in_range = (io_req_addr[15:12] >= win.io_window_low) &&
                    (io_req_addr[15:12] <= win.io_window_high); // [R15]

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      io_fwd_valid_r <= 1'b0;
      io_fwd_hit_r   <= 1'b0;
    end else begin
      io_fwd_valid_r <= io_req_valid;
      io_fwd_hit_r   <= io_req_valid && upper_ok && in_range; // [R13]
    end
  end

endmodule

// ### design/brg_rd_mux.sv
`timescale 1ns/1ps
`include "brg_hdr_consts.svh"

module brg_rd_mux (
  brg_win_if.view                 win,
  input  wire logic [`BRG_IDX_W-1:0] rd_idx,
  output      logic [31:0]        rd_data,
  output      logic               rd_mapped
);

  always_comb begin
    rd_data   = 32'h00000000;
    rd_mapped = 1'b1;
    case (rd_idx)
      `BRG_IDX_PRI_LATENCY:    rd_data[7:0] = `BRG_VAL_PRI_LATENCY; // [R1]
      `BRG_IDX_HEADER_TYPE:    rd_data[7:0] = `BRG_VAL_HEADER_TYPE; // [R2]
      `BRG_IDX_SELF_TEST:      rd_data[7:0] = `BRG_VAL_SELF_TEST; // [R3]
      `BRG_IDX_BASE_ADDR_ZERO: rd_data      = `BRG_VAL_BASE_ADDR; // [R4]
      `BRG_IDX_BASE_ADDR_ONE:  rd_data      = `BRG_VAL_BASE_ADDR; // [R4]
      `BRG_IDX_UPSTREAM_BUS:   rd_data[7:0] = win.upstream_bus_number; // [R5]
      `BRG_IDX_DOWNSTREAM_BUS: rd_data[7:0] = win.downstream_bus_number; // [R6]
      `BRG_IDX_HIGHEST_BUS:    rd_data[7:0] = win.highest_behind_bus_number; // [R7]
      `BRG_IDX_DOWN_LATENCY:   rd_data[7:0] = `BRG_VAL_DOWN_LATENCY; // [R8]
      `BRG_IDX_IO_WINDOW_LOW: begin
        rd_data[`BRG_IO_ADDR_MSB:`BRG_IO_ADDR_LSB] = win.io_window_low; // [R11]
        rd_data[3:1]             = `BRG_IO_RSVD_ZERO; // [R14]
        rd_data[`BRG_IO_CAP_BIT] = win.io_addressing_capability; // [R9]
      end
      `BRG_IDX_IO_WINDOW_HIGH: begin
        rd_data[`BRG_IO_ADDR_MSB:`BRG_IO_ADDR_LSB] = win.io_window_high; // [R12]
        rd_data[3:1]             = `BRG_IO_RSVD_ZERO; // [R14]
        rd_data[`BRG_IO_CAP_BIT] = win.io_addressing_capability; // [R10]
      end
      `BRG_IDX_CAP_UNLOCK:     rd_data[`BRG_CAP_UNLOCK_BIT] = win.cap_unlock;
      default:                 rd_mapped = 1'b0;
    endcase
  end

endmodule

// ### design/brg_hdr_top.sv
// How it works
// [R1] primary latency timer reads zero, read-only
// [R2] header type reads one, read-only
// [R3] self-test byte reads zero, read-only
// [R4] both base address words read zero
// [R5] upstream bus number stores writes, resets zero
// [R6] downstream bus number read/write, resets zero
// [R7] highest behind bus number read/write, resets zero
// [R8] downstream latency timer reads zero, read-only
// [R9] window low bit 0: capability, resets one
// [R10] window high bit 0 mirrors capability
// [R11] window low bits 7:4 writable, reset F
// [R12] window high bits 7:4 writable, reset 0
// [R13] window decides which i/o is forwarded
// [R14] bits 3:1 of both window bytes zero
// [R15] inside when base<=addr[15:12]<=limit, else empty
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "brg_hdr_consts.svh"

module brg_hdr_top #(
  parameter int ADDR_W = 12
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] s_axil_awaddr,
  input  wire logic              s_axil_awvalid,
  output      logic              s_axil_awready,
  input  wire logic [31:0]       s_axil_wdata,
  input  wire logic [3:0]        s_axil_wstrb,
  input  wire logic              s_axil_wvalid,
  output      logic              s_axil_wready,
  output      logic [1:0]        s_axil_bresp,
  output      logic              s_axil_bvalid,
  input  wire logic              s_axil_bready,
  input  wire logic [ADDR_W-1:0] s_axil_araddr,
  input  wire logic              s_axil_arvalid,
  output      logic              s_axil_arready,
  output      logic [31:0]       s_axil_rdata,
  output      logic [1:0]        s_axil_rresp,
  output      logic              s_axil_rvalid,
  input  wire logic              s_axil_rready,
  input  wire logic              io_req_valid,
  input  wire logic [31:0]       io_req_addr,
  output      logic              io_fwd_valid,
  output      logic              io_fwd_hit,
  output      logic [7:0]        downstream_bus_number,
  output      logic [7:0]        highest_behind_bus_number
);

  brg_win_if win ();

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  logic                  [7:0]            upstream_bus_r;
  logic                  [7:0]            downstream_bus_r;
  logic                  [7:0]            highest_bus_r;
  logic                  [3:0]            io_low_addr_r;
  logic                  [3:0]            io_high_addr_r;
  brg_pkg::brg_io_mode_t                  io_cap_r;
  logic                                   cap_unlock_r;

  // ----------------------------------------------------------------------
  // bus slave state
  // ----------------------------------------------------------------------
  brg_pkg::brg_wr_state_t                 wr_state_r;
  logic                                   have_aw_r;
  logic                                   have_w_r;
  logic                  [`BRG_IDX_W-1:0] wr_idx_r;
  logic                  [31:0]           wr_data_r;
  logic                  [3:0]            wr_strb_r;
  logic                                   awready_r;
  logic                                   wready_r;
  logic                                   bvalid_r;
  brg_pkg::brg_resp_t                     bresp_r;
  logic                                   arready_r;
  logic                                   rvalid_r;
  logic                  [31:0]           rdata_r;
  brg_pkg::brg_resp_t                     rresp_r;

  logic                                   aw_take;
  logic                                   w_take;
  logic                                   wr_fire;
  logic                                   ar_take;
  logic                  [`BRG_IDX_W-1:0] ar_idx;
  logic                  [31:0]           rd_data;
  logic                                   rd_mapped;
  logic                                   wr_mapped;
  logic                                   lane0;

  // ----------------------------------------------------------------------
  // write channels
  // ----------------------------------------------------------------------
  // address and data are caught independently in either order; the
  // ready of each drops once it holds a beat until the answer is taken
  assign aw_take = s_axil_awvalid && awready_r;
  assign w_take  = s_axil_wvalid && wready_r;
  assign wr_fire = (wr_state_r == brg_pkg::brg_wr_collect) && have_aw_r && have_w_r;
  assign lane0   = wr_strb_r[`BRG_STRB_LOW_LANE];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      have_aw_r <= 1'b0;
      wr_idx_r  <= '0;
      awready_r <= 1'b1;
    end else begin
      if (aw_take) begin
        have_aw_r <= 1'b1;
        wr_idx_r  <= s_axil_awaddr[`BRG_IDX_MSB:`BRG_IDX_LSB];
        awready_r <= 1'b0;
      end else if (s_axil_bvalid && s_axil_bready) begin
        have_aw_r <= 1'b0;
        awready_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      have_w_r  <= 1'b0;
      wr_data_r <= 32'h00000000;
      wr_strb_r <= 4'h0;
      wready_r  <= 1'b1;
    end else begin
      if (w_take) begin
        have_w_r  <= 1'b1;
        wr_data_r <= s_axil_wdata;
        wr_strb_r <= s_axil_wstrb;
        wready_r  <= 1'b0;
      end else if (s_axil_bvalid && s_axil_bready) begin
        have_w_r <= 1'b0;
        wready_r <= 1'b1;
      end
    end
  end

  always_comb begin
    case (wr_idx_r)
      `BRG_IDX_PRI_LATENCY, `BRG_IDX_HEADER_TYPE, `BRG_IDX_SELF_TEST,
      `BRG_IDX_BASE_ADDR_ZERO, `BRG_IDX_BASE_ADDR_ONE, `BRG_IDX_UPSTREAM_BUS,
      `BRG_IDX_DOWNSTREAM_BUS, `BRG_IDX_HIGHEST_BUS, `BRG_IDX_DOWN_LATENCY,
      `BRG_IDX_IO_WINDOW_LOW, `BRG_IDX_IO_WINDOW_HIGH, `BRG_IDX_CAP_UNLOCK:
        wr_mapped = 1'b1;
      default:
        wr_mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // write answer
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_state_r <= brg_pkg::brg_wr_collect;
      bvalid_r   <= 1'b0;
      bresp_r    <= brg_pkg::brg_resp_okay;
    end else begin
      unique case (wr_state_r)
        brg_pkg::brg_wr_collect: begin
          if (wr_fire) begin
            wr_state_r <= brg_pkg::brg_wr_answer;
            bvalid_r   <= 1'b1;
            bresp_r    <= wr_mapped ? brg_pkg::brg_resp_okay : brg_pkg::brg_resp_decerr;
          end
        end
        brg_pkg::brg_wr_answer: begin
          if (s_axil_bready) begin
            wr_state_r <= brg_pkg::brg_wr_collect;
            bvalid_r   <= 1'b0;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // writable bus numbers
  // ----------------------------------------------------------------------
  // read-only bytes simply ignore writes and still answer okay, so old
  // enumeration code that rewrites the whole header does not fault
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      upstream_bus_r   <= `BRG_RST_BUS_NUMBER;
      downstream_bus_r <= `BRG_RST_BUS_NUMBER;
      highest_bus_r    <= `BRG_RST_BUS_NUMBER;
    end else if (wr_fire && lane0) begin
      if (wr_idx_r == `BRG_IDX_UPSTREAM_BUS) begin
        upstream_bus_r <= wr_data_r[7:0]; // [R5]
      end
      if (wr_idx_r == `BRG_IDX_DOWNSTREAM_BUS) begin
        downstream_bus_r <= wr_data_r[7:0]; // [R6]
      end
      if (wr_idx_r == `BRG_IDX_HIGHEST_BUS) begin
        highest_bus_r <= wr_data_r[7:0]; // [R7]
      end
    end
  end

  // ----------------------------------------------------------------------
  // i/o window
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      io_low_addr_r  <= `BRG_RST_IO_LOW_ADDR;
      io_high_addr_r <= `BRG_RST_IO_HIGH_ADDR;
    end else if (wr_fire && lane0) begin
      if (wr_idx_r == `BRG_IDX_IO_WINDOW_LOW) begin
        io_low_addr_r <= wr_data_r[`BRG_IO_ADDR_MSB:`BRG_IO_ADDR_LSB]; // [R11]
      end
      if (wr_idx_r == `BRG_IDX_IO_WINDOW_HIGH) begin
        io_high_addr_r <= wr_data_r[`BRG_IO_ADDR_MSB:`BRG_IO_ADDR_LSB]; // [R12]
      end
    end
  end

  // the capability bit is locked against ordinary writes; only with the
  // unlock bit set does a write to the low window byte change it, which
  // keeps careless software from flipping the addressing width
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      io_cap_r <= brg_pkg::brg_io_mode_t'(`BRG_RST_IO_CAP); // [R9]
    end else if (wr_fire && lane0 && cap_unlock_r &&
                 (wr_idx_r == `BRG_IDX_IO_WINDOW_LOW)) begin
      io_cap_r <= brg_pkg::brg_io_mode_t'(wr_data_r[`BRG_IO_CAP_BIT]); // [R9]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cap_unlock_r <= `BRG_RST_CAP_UNLOCK;
    end else if (wr_fire && lane0 && (wr_idx_r == `BRG_IDX_CAP_UNLOCK)) begin
      cap_unlock_r <= wr_data_r[`BRG_CAP_UNLOCK_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------------
  assign ar_take = s_axil_arvalid && arready_r;
  assign ar_idx  = s_axil_araddr[`BRG_IDX_MSB:`BRG_IDX_LSB];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h00000000;
      rresp_r   <= brg_pkg::brg_resp_okay;
    end else begin
      if (ar_take) begin
        arready_r <= 1'b0;
        rvalid_r  <= 1'b1;
        rdata_r   <= rd_data;
        rresp_r   <= rd_mapped ? brg_pkg::brg_resp_okay : brg_pkg::brg_resp_decerr;
      end else if (rvalid_r && s_axil_rready) begin
        arready_r <= 1'b1;
        rvalid_r  <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // shared view and children
  // ----------------------------------------------------------------------
  assign win.io_window_low             = io_low_addr_r;
  assign win.io_window_high            = io_high_addr_r;
  assign win.io_addressing_capability  = io_cap_r;
  assign win.upstream_bus_number       = upstream_bus_r;
  assign win.downstream_bus_number     = downstream_bus_r;
  assign win.highest_behind_bus_number = highest_bus_r;
  assign win.cap_unlock                = cap_unlock_r;

  brg_rd_mux u_rd_mux (
    .win       (win.view),
    .rd_idx    (ar_idx),
    .rd_data   (rd_data),
    .rd_mapped (rd_mapped)
  );

  brg_io_decode u_io_decode (
    .sys_clk        (sys_clk),
    .rst_b          (rst_b),
    .win            (win.view),
    .io_req_valid   (io_req_valid),
    .io_req_addr    (io_req_addr),
    .io_fwd_valid_r (io_fwd_valid),
    .io_fwd_hit_r   (io_fwd_hit)
  );

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign s_axil_awready            = awready_r;
  assign s_axil_wready             = wready_r;
  assign s_axil_bvalid             = bvalid_r;
  assign s_axil_bresp              = bresp_r;
  assign s_axil_arready            = arready_r;
  assign s_axil_rvalid             = rvalid_r;
  assign s_axil_rdata              = rdata_r;
  assign s_axil_rresp              = rresp_r;
  assign downstream_bus_number     = downstream_bus_r;
  assign highest_behind_bus_number = highest_bus_r;

endmodule

// ### tb/brg_hdr_sva.sv
`timescale 1ns/1ps

module brg_hdr_sva #(
  parameter int ADDR_W = 12
) (
  input wire logic              sys_clk,
  input wire logic              rst_b,
  input wire logic [ADDR_W-1:0] s_axil_awaddr,
  input wire logic              s_axil_awvalid,
  input wire logic              s_axil_awready,
  input wire logic [31:0]       s_axil_wdata,
  input wire logic [3:0]        s_axil_wstrb,
  input wire logic              s_axil_wvalid,
  input wire logic              s_axil_wready,
  input wire logic [1:0]        s_axil_bresp,
  input wire logic              s_axil_bvalid,
  input wire logic              s_axil_bready,
  input wire logic [ADDR_W-1:0] s_axil_araddr,
  input wire logic              s_axil_arvalid,
  input wire logic              s_axil_arready,
  input wire logic [31:0]       s_axil_rdata,
  input wire logic [1:0]        s_axil_rresp,
  input wire logic              s_axil_rvalid,
  input wire logic              s_axil_rready,
  input wire logic              io_req_valid,
  input wire logic [31:0]       io_req_addr,
  input wire logic              io_fwd_valid,
  input wire logic              io_fwd_hit,
  input wire logic [7:0]        downstream_bus_number,
  input wire logic [7:0]        highest_behind_bus_number
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------------------------------------
  // write and read channels
  // ----------------------------------------------------------------------
  sequence wr_taken_s;
    s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
  endsequence

  sequence wr_answer_s;
    !s_axil_awready && !s_axil_wready && !s_axil_bvalid ##1 s_axil_bvalid;
  endsequence

  wr_answer_a: assert property (wr_taken_s |=> wr_answer_s)
    else $error("write answer not one cycle after update");
  b_hold_a: assert property (s_axil_bvalid && !s_axil_bready |=>
    s_axil_bvalid && $stable(s_axil_bresp)) else $error("write answer dropped early");
  b_release_a: assert property (s_axil_bvalid && s_axil_bready |=>
    !s_axil_bvalid && s_axil_awready && s_axil_wready) else $error("write side not reopened");
  rd_answer_a: assert property (s_axil_arvalid && s_axil_arready |=>
    s_axil_rvalid && !s_axil_arready) else $error("read answer late");
  r_hold_a: assert property (s_axil_rvalid && !s_axil_rready |=>
    s_axil_rvalid && $stable(s_axil_rdata) && $stable(s_axil_rresp))
    else $error("read answer changed while waiting");
  decerr_zero_a: assert property (s_axil_rvalid && s_axil_rresp == 2'h3 |->
    s_axil_rdata == 32'h0) else $error("unmapped read returned data");
  byte_regs_a: assert property (s_axil_rvalid |-> s_axil_rdata[31:8] == 24'h0)
    else $error("upper bytes of a byte register not zero");

  // ----------------------------------------------------------------------
  // window decode and bus number outputs
  // ----------------------------------------------------------------------
  fwd_follow_a: assert property (1'h1 |=> io_fwd_valid == $past(io_req_valid))
    else $error("forward pulse not one cycle after request");
  hit_in_pulse_a: assert property (io_fwd_hit |-> io_fwd_valid)
    else $error("hit outside forward pulse");
  bus_num_wr_a: assert property (!$stable(downstream_bus_number) ||
    !$stable(highest_behind_bus_number) |-> !$past(s_axil_awready))
    else $error("bus number changed without a write");
endmodule

bind brg_hdr_top brg_hdr_sva #(.ADDR_W(ADDR_W)) brg_hdr_sva_i (.*);

// ### tb/tb_bridge_header_bus_io_window.sv
`timescale 1ns/1ps

module tb_bridge_header_bus_io_window;
  logic        sys_clk;
  logic        rst_b;
  logic [11:0] s_axil_awaddr;
  logic        s_axil_awvalid;
  logic        s_axil_awready;
  logic [31:0] s_axil_wdata;
  logic [3:0]  s_axil_wstrb;
  logic        s_axil_wvalid;
  logic        s_axil_wready;
  logic [1:0]  s_axil_bresp;
  logic        s_axil_bvalid;
  logic        s_axil_bready;
  logic [11:0] s_axil_araddr;
  logic        s_axil_arvalid;
  logic        s_axil_arready;
  logic [31:0] s_axil_rdata;
  logic [1:0]  s_axil_rresp;
  logic        s_axil_rvalid;
  logic        s_axil_rready;
  logic        io_req_valid;
  logic [31:0] io_req_addr;
  logic        io_fwd_valid;
  logic        io_fwd_hit;
  logic [7:0]  downstream_bus_number;
  logic [7:0]  highest_behind_bus_number;
  int          n_errors;
  int          check_count;

  brg_hdr_top #(.ADDR_W(12)) brg_hdr_top_i (.*);

  initial begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // every wait in axi_wr and axi_rd goes through here so a hung handshake ends the run
  task automatic tick(inout int n);
    @(posedge sys_clk);
    n++;
    if (n > 40) begin
      $display("timeout at %0t", $time);
      n_errors++;
      wrap_up();
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    check_count++;
    if (got !== want) begin
      n_errors++;
      $display("mismatch at %0t got %h want %h", $time, got, want);
    end
  endtask

  task automatic axi_wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] st,
                        input logic [1:0] rsp);
    int   n    = 0;
    logic aw_p = 1'h1;
    logic w_p  = 1'h1;
    s_axil_awaddr  <= {2'h0, idx, 2'h0};
    s_axil_wdata   <= d;
    s_axil_wstrb   <= st;
    s_axil_awvalid <= 1'h1;
    s_axil_wvalid  <= 1'h1;
    while (aw_p || w_p) begin
      tick(n);
      if (aw_p && s_axil_awready) begin
        aw_p = 1'h0;
        s_axil_awvalid <= 1'h0;
      end
      if (w_p && s_axil_wready) begin
        w_p = 1'h0;
        s_axil_wvalid <= 1'h0;
      end
    end
    do tick(n); while (!s_axil_bvalid);
    s_axil_bready <= 1'h1;
    tick(n);
    s_axil_bready <= 1'h0;
    chk({30'h0, s_axil_bresp}, {30'h0, rsp});
  endtask

  task automatic axi_rd(input logic [7:0] idx, input logic [31:0] want, input logic [1:0] rsp);
    int n = 0;
    s_axil_araddr  <= {2'h0, idx, 2'h0};
    s_axil_arvalid <= 1'h1;
    do tick(n); while (!s_axil_arready);
    s_axil_arvalid <= 1'h0;
    do tick(n); while (!s_axil_rvalid);
    s_axil_rready  <= 1'h1;
    tick(n);
    s_axil_rready  <= 1'h0;
    chk(s_axil_rdata, want);
    chk({30'h0, s_axil_rresp}, {30'h0, rsp});
  endtask

  function automatic logic exp_hit(input logic [3:0] lo, input logic [3:0] hi,
                                   input logic cap, input logic [31:0] a);
    return (lo <= a[15:12]) && (a[15:12] <= hi) && (cap || a[31:16] == 16'h0);
  endfunction

  // requests go out back to back, one every cycle
  task automatic io_run(input logic [3:0] lo, input logic [3:0] hi, input logic cap,
                        input logic [31:0] a [6]);
    for (int i = 0; i < 7; i++) begin
      io_req_valid <= 1'(i < 6);
      io_req_addr  <= a[i % 6];
      @(posedge sys_clk);
      if (i > 0) begin
        chk({31'h0, io_fwd_valid}, 32'h1);
        chk({31'h0, io_fwd_hit}, {31'h0, exp_hit(lo, hi, cap, a[i - 1])});
      end
    end
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    logic [7:0]  idx [12] = '{8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h14, 8'h18, 8'h19, 8'h1A,
                              8'h1B, 8'h1C, 8'h1D, 8'h11};
    logic [31:0] want [12] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
                               32'h0, 32'hF1, 32'h1, 32'h0};
    for (int i = 0; i < 12; i++) begin
      axi_rd(idx[i], want[i], (i == 11) ? 2'h3 : 2'h0);
    end
    chk({24'h0, downstream_bus_number}, 32'h0);
    chk({24'h0, highest_behind_bus_number}, 32'h0);
    $display("test reset_values done");
  endtask

  task automatic t_read_only();
    logic [7:0]  idx [7] = '{8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h14, 8'h1B, 8'h11};
    logic [31:0] want [7] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 7; i++) begin
      axi_wr(idx[i], 32'hFFFF_FFFF, 4'hF, (i == 6) ? 2'h3 : 2'h0);
      axi_rd(idx[i], want[i], (i == 6) ? 2'h3 : 2'h0);
    end
    $display("test read_only done");
  endtask

  task automatic t_bus_numbers();
    axi_wr(8'h18, 32'h0000_00A5, 4'h1, 2'h0);
    axi_wr(8'h19, 32'hFFFF_FF3C, 4'h1, 2'h0);
    axi_wr(8'h1A, 32'h0000_007E, 4'h1, 2'h0);
    axi_rd(8'h18, 32'hA5, 2'h0);
    axi_rd(8'h19, 32'h3C, 2'h0);
    axi_rd(8'h1A, 32'h7E, 2'h0);
    chk({24'h0, downstream_bus_number}, 32'h3C);
    chk({24'h0, highest_behind_bus_number}, 32'h7E);
    // low lane disabled: nothing may change
    axi_wr(8'h19, 32'h0000_0011, 4'hE, 2'h0);
    axi_rd(8'h19, 32'h3C, 2'h0);
    $display("test bus_numbers done");
  endtask

  task automatic t_window();
    logic [31:0] a1 [6] = '{32'h2FFF, 32'h3000, 32'h5FFF, 32'h6000, 32'h0001_4000, 32'h3ABC};
    logic [31:0] a2 [6] = '{32'h5000, 32'h6000, 32'h5FFF, 32'h6FFF, 32'h0, 32'hFFFF};
    axi_wr(8'h1C, 32'h3E, 4'h1, 2'h0);
    axi_rd(8'h1C, 32'h31, 2'h0);
    axi_wr(8'h1D, 32'h5E, 4'h1, 2'h0);
    axi_rd(8'h1D, 32'h51, 2'h0);
    io_run(4'h3, 4'h5, 1'h1, a1);
    axi_wr(8'h1C, 32'h60, 4'h1, 2'h0);
    io_run(4'h6, 4'h5, 1'h1, a2);
    $display("test window done");
  endtask

  task automatic t_capability();
    logic [31:0] a3 [6] = '{32'h0001_3000, 32'h3000, 32'h4FFF, 32'h8000_4000, 32'h2FFF, 32'h5FFF};
    axi_wr(8'h40, 32'h1, 4'h1, 2'h0);
    axi_rd(8'h40, 32'h1, 2'h0);
    axi_wr(8'h1C, 32'h30, 4'h1, 2'h0);
    axi_rd(8'h1C, 32'h30, 2'h0);
    axi_rd(8'h1D, 32'h50, 2'h0);
    io_run(4'h3, 4'h5, 1'h0, a3);
    axi_wr(8'h40, 32'h0, 4'h1, 2'h0);
    axi_wr(8'h1C, 32'h31, 4'h1, 2'h0);
    axi_rd(8'h1C, 32'h30, 2'h0);
    $display("test capability done");
  endtask

  initial begin
    n_errors = 0;
    check_count = 0;
    rst_b = 1'h0;
    {s_axil_awaddr, s_axil_awvalid, s_axil_wdata, s_axil_wstrb, s_axil_wvalid} = '0;
    {s_axil_bready, s_axil_araddr, s_axil_arvalid, s_axil_rready} = '0;
    {io_req_valid, io_req_addr} = '0;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'h1;
    @(posedge sys_clk);
    t_reset();
    t_read_only();
    t_bus_numbers();
    t_window();
    t_capability();
    // reset again in mid-run: everything must return to its reset value
    rst_b <= 1'h0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'h1;
    @(posedge sys_clk);
    t_reset();
    wrap_up();
  end
endmodule
